// *** rtl/rpc_defines.vh ***
// Constants for the real-time clock pin control block.
// Assumes inclusion by bare name from the rtl folder.
`ifndef RPC_DEFINES_VH
`define RPC_DEFINES_VH
`define RPC_SEL_W        4
`define RPC_SEL_OFF      4'h0
`define RPC_STAT_W       8
`define RPC_STAT_RST     8'h00
`define RPC_STAT_CLK_BIT 6
`define RPC_STAT_ALM_BIT 7
`define RPC_TAP_W        16
`endif

// *** rtl/rpc_sync.v ***
// Two-flop synchroniser for one pin level.
// Assumes the pin is asynchronous to I_CORE_CLK.
`timescale 1ns/1ps
module rpc_sync #(
   parameter       RST_VAL = 1'b0  // Level held while in reset.
) (
   input  wire     i_clk,          // Core clock.
   input  wire     i_srst,         // Synchronous reset, active high.
   input  wire     i_d,            // Asynchronous pin level.
   output wire     o_q             // Synchronised level.
);
   reg meta_ff;
   reg sync_ff;

   // The first flop feeds only the second.
   always @(posedge i_clk) begin
      if (i_srst) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= i_d;
         sync_ff <= meta_ff;
      end
   end

   assign o_q = sync_ff;
endmodule // rpc_sync

// *** rtl/rpc_pin_ctrl.v ***
// Pin control of a real-time clock: chip-select latch, square-wave out,
// power-down, interrupt output and reset.
// Assumes the counter chain supplies a tap vector and an alarm match on
// I_CORE_CLK; all pins pass a two-flop synchroniser first.
`timescale 1ns/1ps
`include "rpc_defines.vh"

// Operation
// - Latched select gates all pin accesses.
// - Square output follows one of fifteen taps.
// - Sleep forces square output low.
// - No rate selected holds output high outside power-down.
// - Low sleep pin enters power-down.
// - Alarm or square fall pulls interrupt low.
// - Reset clears status, interrupt high.
// - Power-down tri-states the interrupt pin while no event is pending.
// - Alarm still wakes host during power-down.
// - Control write withdraws the interrupt.
// - Select captured on strobe trailing edge.
// - Bus inputs ignored during power-down.
// - Pending access finishes before power-down.
// - First square fall sets status bit six.
module rpc_pin_ctrl (
   input  wire       I_CORE_CLK,         // Core clock, 125 MHz.
   input  wire       I_SRST,             // Synchronous reset, active high.
   input  wire       I_RESET_N,          // Reset pin, active low.
   input  wire       I_DEV_SEL,          // Device-select pin, active high.
   input  wire       I_ADDRESS_STROBE,   // Address strobe pin.
   input  wire       I_WRITE_STROBE_N,   // Write strobe pin, active low.
   input  wire       I_READ_N,           // Read strobe pin, active low.
   input  wire       I_SLEEP_N,          // Power-down pin, active low.
   input  wire [3:0] I_RATE_SEL,         // Control register upper nibble.
   input  wire       I_CTRL_WR,          // Control register write, pulse.
   input  wire [15:0] I_TAPS,            // Counter and prescaler taps.
   input  wire       I_ALARM_MATCH,      // Alarm match, pulse.
   input  wire       I_ALARM_EN,         // Alarm enabled.
   output reg        O_SEL_ACTIVE,       // Latched select, I/O enabled.
   output reg        O_WR_ACCEPT,        // Write taken, one-cycle pulse.
   output reg        O_RD_ACTIVE,        // Read in progress, level.
   output reg        O_SQ_WAVE,          // Square-wave output pin.
   output reg        O_INT_N_O,          // Interrupt pin output value.
   output reg        O_INT_N_OE,         // Interrupt pin output enable.
   output reg        O_POWER_DOWN,       // Power-down mode active.
   output reg  [7:0] O_STATUS            // Interrupt status register.
);
   // Synchronised pin levels.
   wire                   rst_n_s;     // Reset pin, active low.
   wire                   sel_s;       // Device-select pin.
   wire                   as_s;        // Address strobe pin.
   wire                   wr_n_s;      // Write strobe pin, active low.
   wire                   rd_n_s;      // Read strobe pin, active low.
   wire                   sleep_n_s;   // Power-down pin, active low.

   // Delayed copies for edge detection.
   reg                    as_d_ff;     // Strobe one cycle back.
   reg                    wr_n_d_ff;   // Write strobe one cycle back.
   reg                    sq_d_ff;     // Raw wave one cycle back.

   // Next values of the output registers.
   reg                    nxt_sel;
   reg                    nxt_wr_acc;
   reg                    nxt_rd;
   reg                    nxt_pd;
   reg                    nxt_sq;
   reg                    nxt_int_n;
   reg                    nxt_int_oe;
   reg [`RPC_STAT_W-1:0]  nxt_stat;

   // Decoded conditions.
   wire                   sq_raw;      // Selected tap, high when off.
   wire                   sq_fall;     // Falling edge of the raw wave.
   wire                   as_fall;     // Trailing edge of the strobe.
   wire                   wr_rise;     // Trailing edge of the write.
   wire                   access;      // Access open on the bus.
   wire                   clr;         // Status clear request.

   // Tap selection for the fifteen square-wave rates.
   function tap_pick;
      input [3:0]  sel;
      input [15:0] taps;
      begin
         tap_pick = taps[sel];
      end
   endfunction

   // An interrupt is pending while either event bit is set.
   function irq_pend;
      input [`RPC_STAT_W-1:0] stat;
      begin
         irq_pend = stat[`RPC_STAT_CLK_BIT] | stat[`RPC_STAT_ALM_BIT];
      end
   endfunction

   rpc_sync #(.RST_VAL(1'b1)) u_rst (.i_clk(I_CORE_CLK), .i_srst(I_SRST),
      .i_d(I_RESET_N), .o_q(rst_n_s));
   rpc_sync #(.RST_VAL(1'b0)) u_sel (.i_clk(I_CORE_CLK), .i_srst(I_SRST),
      .i_d(I_DEV_SEL), .o_q(sel_s));
   rpc_sync #(.RST_VAL(1'b0)) u_as (.i_clk(I_CORE_CLK), .i_srst(I_SRST),
      .i_d(I_ADDRESS_STROBE), .o_q(as_s));
   rpc_sync #(.RST_VAL(1'b1)) u_wr (.i_clk(I_CORE_CLK), .i_srst(I_SRST),
      .i_d(I_WRITE_STROBE_N), .o_q(wr_n_s));
   rpc_sync #(.RST_VAL(1'b1)) u_rd (.i_clk(I_CORE_CLK), .i_srst(I_SRST),
      .i_d(I_READ_N), .o_q(rd_n_s));
   rpc_sync #(.RST_VAL(1'b1)) u_slp (.i_clk(I_CORE_CLK), .i_srst(I_SRST),
      .i_d(I_SLEEP_N), .o_q(sleep_n_s));

   // Raw square wave: high when no rate is chosen.
   assign sq_raw  = (I_RATE_SEL == `RPC_SEL_OFF) ? 1'b1 :
                    tap_pick(I_RATE_SEL, I_TAPS);
   assign sq_fall = sq_d_ff & ~sq_raw;
   // Strobe trailing edges, seen after the synchronisers.
   assign as_fall = as_d_ff & ~as_s;
   assign wr_rise = ~wr_n_d_ff & wr_n_s;
   // An access is open while a write or read strobe is active with select latched.
   assign access  = O_SEL_ACTIVE & (~wr_n_s | ~rd_n_s);
   assign clr     = ~rst_n_s | I_CTRL_WR;

   // Select latch: the strobe is ignored in power-down, select kept.
   always @* begin
      nxt_sel = O_SEL_ACTIVE;
      if (as_fall & ~O_POWER_DOWN)
         nxt_sel = sel_s;
   end

   // Bus strobes: both need the latch and are refused in power-down.
   // A cycle already open when power-down is asked for still lands,
   // because the mode waits until the strobes have closed.
   always @* begin
      nxt_wr_acc = O_SEL_ACTIVE & wr_rise & rd_n_s
                   & ~O_POWER_DOWN;
      nxt_rd     = O_SEL_ACTIVE & ~rd_n_s & wr_n_s
                   & ~O_POWER_DOWN;
   end

   // Power-down follows a low pin once no access is open, and a high pin at once.
   always @* begin
      nxt_pd = O_POWER_DOWN;
      if (sleep_n_s)
         nxt_pd = 1'b0;
      else if (~access)
         nxt_pd = 1'b1;
   end

   // Square-wave pin: forced low in power-down.
   always @* begin
      nxt_sq = nxt_pd ? 1'b0 : sq_raw;
   end

   // Status: events win over a control write, a reset pin over both.
   always @* begin
      nxt_stat = O_STATUS;
      if (clr)
         nxt_stat = `RPC_STAT_RST;
      if (rst_n_s) begin
         if (sq_fall)
            nxt_stat[`RPC_STAT_CLK_BIT] = 1'b1;
         if (I_ALARM_MATCH & I_ALARM_EN)
            nxt_stat[`RPC_STAT_ALM_BIT] = 1'b1;
      end
   end

   // Interrupt pin: low while an event is pending; released in
   // power-down unless an event must wake the host.
   always @* begin
      nxt_int_n  = ~irq_pend(nxt_stat);
      nxt_int_oe = ~nxt_pd | irq_pend(nxt_stat);
   end

   // Edge-detect history; reset values match the idle pin levels.
   always @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         as_d_ff   <= 1'b0;
         wr_n_d_ff <= 1'b1;
         sq_d_ff   <= 1'b1;
      end else begin
         as_d_ff   <= as_s;
         wr_n_d_ff <= wr_n_s;
         sq_d_ff   <= sq_raw;
      end
   end

   // Bus side outputs: select latch, write pulse and read level.
   always @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         O_SEL_ACTIVE <= 1'b0;
         O_WR_ACCEPT  <= 1'b0;
         O_RD_ACTIVE  <= 1'b0;
      end else begin
         O_SEL_ACTIVE <= nxt_sel;
         O_WR_ACCEPT  <= nxt_wr_acc;
         O_RD_ACTIVE  <= nxt_rd;
      end
   end

   // Mode flag and square-wave pin.
   always @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         O_POWER_DOWN <= 1'b0;
         O_SQ_WAVE    <= 1'b1;
      end else begin
         O_POWER_DOWN <= nxt_pd;
         O_SQ_WAVE    <= nxt_sq;
      end
   end

   // Status register and interrupt pin.
   always @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         O_STATUS   <= `RPC_STAT_RST;
         O_INT_N_O  <= 1'b1;
         O_INT_N_OE <= 1'b1;
      end else begin
         O_STATUS   <= nxt_stat;
         O_INT_N_O  <= nxt_int_n;
         O_INT_N_OE <= nxt_int_oe;
      end
   end
endmodule // rpc_pin_ctrl

// *** tb/rpc_pin_ctrl_chk.sv ***
// Assertions on the pin control outputs.
// Assumes a bind to rpc_pin_ctrl; pins pass 2-flop syncs first.
`timescale 1ns/1ps
module rpc_chk (
   input wire        I_CORE_CLK, I_SRST, I_RESET_N, I_SLEEP_N, I_READ_N,
   input wire        I_WRITE_STROBE_N, I_CTRL_WR, I_ALARM_MATCH, I_ALARM_EN,
   input wire [3:0]  I_RATE_SEL,
   input wire [15:0] I_TAPS,
   input wire        O_SQ_WAVE, O_INT_N_O, O_INT_N_OE, O_POWER_DOWN,
   input wire [7:0]  O_STATUS
);
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (I_SRST);
   // Normal running, and a reset pin that has been high long enough.
   wire run = !O_POWER_DOWN;
   sequence pin_up; I_RESET_N [*4]; endsequence
   a_sq_idle: assert property (run && I_RATE_SEL == 4'h0 ##1 run
      |-> O_SQ_WAVE) else $error("square not high");
   a_sq_rate: assert property (run && I_RATE_SEL != 4'h0 ##1 run
      |-> O_SQ_WAVE == $past(I_TAPS[I_RATE_SEL])) else $error("bad tap");
   a_pd_sq_low: assert property (O_POWER_DOWN |-> !O_SQ_WAVE)
      else $error("square not low in sleep");
   a_pd_enter: assert property (
      (!I_SLEEP_N && I_READ_N && I_WRITE_STROBE_N) [*6] |-> O_POWER_DOWN)
      else $error("no power-down");
   a_pd_hiz: assert property (O_POWER_DOWN && O_INT_N_O |-> !O_INT_N_OE)
      else $error("interrupt driven in sleep");
   a_alarm_wake: assert property (pin_up ##0 I_ALARM_MATCH && I_ALARM_EN
      |=> !O_INT_N_O && O_INT_N_OE && O_STATUS[7]) else $error("no wake");
   a_sq_fall_int: assert property (pin_up ##0 $fell(O_SQ_WAVE) && run
      |-> ##[0:1] !O_INT_N_O && O_STATUS[6]) else $error("no fall event");
   a_ctrl_clear: assert property (
      I_CTRL_WR && I_RATE_SEL == 4'h0 && !I_ALARM_MATCH
      |=> O_INT_N_O && O_STATUS == 8'h00) else $error("write no clear");
   a_reset_pin: assert property (!I_RESET_N [*4]
      |-> O_INT_N_O && O_STATUS == 8'h00) else $error("pin no clear");
   c_pd: cover property ($rose(O_POWER_DOWN));
   c_alarm: cover property (I_ALARM_MATCH && O_POWER_DOWN);
   c_fall: cover property ($fell(O_SQ_WAVE) && run);
endmodule // rpc_chk

// *** tb/rpc_host.sv ***
// Host bus model: select, strobes and power-down request.
// Assumes the bench calls its tasks; outputs change at a rising edge.
`timescale 1ns/1ps
module rpc_host (
   input  wire  clk,   // Core clock.
   output logic sel,   // Device select.
   output logic as,    // Address strobe.
   output logic wr_n,  // Write strobe.
   output logic rd_n,  // Read strobe.
   output logic slp_n  // Power-down request.
);
   initial {sel, as, wr_n, rd_n, slp_n} = 5'b00111;
   // Select and strobe first, then one write or read pulse.
   task cyc(input logic s, input logic w);
      @(posedge clk) sel <= s;
      as <= 1'b1;
      repeat (3) @(posedge clk);
      as <= 1'b0;
      repeat (4) @(posedge clk);
      if (w) wr_n <= 1'b0; else rd_n <= 1'b0;
      repeat (4) @(posedge clk);
      {wr_n, rd_n} <= 2'b11;
      repeat (4) @(posedge clk);
      sel <= 1'b0;
   endtask
   // Change the power-down request at the next edge, with no wait.
   task pd_req(input logic lvl);
      @(posedge clk) slp_n <= lvl;
   endtask
   // Stay deselected a while, then change the power-down request.
   task sleep(input logic lvl);
      repeat (250) @(posedge clk);
      slp_n <= lvl;
   endtask
endmodule // rpc_host

// *** tb/testbench.sv ***
// Self-checking bench for the pin control block.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
module testbench;
   logic clk, srst, rst_n, cwr, alm, alm_en, sel, as, wr_n, rd_n, slp_n;
   logic o_sel, o_wr, o_rd, sq, int_o, int_oe, pd;
   logic [3:0] rate;
   logic [15:0] taps;
   logic [7:0] st;
   int n_fail, comparisons, n_wr, n_rd, cyc_cnt;
   rpc_pin_ctrl rpc_pin_ctrl_i (.I_CORE_CLK(clk), .I_SRST(srst),
      .I_RESET_N(rst_n), .I_DEV_SEL(sel), .I_ADDRESS_STROBE(as),
      .I_WRITE_STROBE_N(wr_n), .I_READ_N(rd_n), .I_SLEEP_N(slp_n),
      .I_RATE_SEL(rate), .I_CTRL_WR(cwr), .I_TAPS(taps), .I_ALARM_MATCH(alm),
      .I_ALARM_EN(alm_en), .O_SEL_ACTIVE(o_sel), .O_WR_ACCEPT(o_wr),
      .O_RD_ACTIVE(o_rd), .O_SQ_WAVE(sq), .O_INT_N_O(int_o),
      .O_INT_N_OE(int_oe), .O_POWER_DOWN(pd), .O_STATUS(st));
   rpc_host rpc_host_i (.clk(clk), .sel(sel), .as(as), .wr_n(wr_n),
      .rd_n(rd_n), .slp_n(slp_n));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Counts taken writes and cuts a hang short.
   always @(posedge clk) begin
      if (o_wr === 1'b1) n_wr <= n_wr + 1;
      if (o_rd === 1'b1) n_rd <= n_rd + 1;
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 5000) begin
         n_fail++;
         finish_test();
      end
   end
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task chk(input string nm, input logic [15:0] s, e);
      comparisons++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", nm, e, s);
      end
   endtask
   task finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Write with and without select; only the selected one lands.
   task t_sel();
      rpc_host_i.cyc(1'b1, 1'b1);
      @(negedge clk) chk("sel", {o_sel, n_wr[7:0]}, 9'h101);
      rpc_host_i.cyc(1'b0, 1'b1);
      rpc_host_i.cyc(1'b1, 1'b0);
      @(negedge clk) chk("desel", {o_sel, n_wr[7:0]}, 9'h101);
      chk("rd", n_rd[15:0], 16'h0004);
   endtask
   // Every rate: follow a tap, flag its fall, clear on a write.
   task t_rates();
      for (int r = 1; r < 16; r++) begin
         tick(1);
         rate <= r[3:0];
         taps <= 16'hffff;
         tick(3);
         taps <= ~(16'h0001 << r);
         tick(3);
         @(negedge clk) chk("fall", {int_o, st}, 9'h040);
         tick(1);
         rate <= 4'h0;
         cwr <= 1'b1;
         tick(1);
         cwr <= 1'b0;
         tick(2);
         @(negedge clk) chk("clear", {int_o, sq, st}, 10'h300);
      end
   endtask
   // Sleep with an armed alarm, bus ignored, wake, then reset pin.
   task t_sleep();
      tick(1);
      rate <= 4'h1;
      taps <= 16'hffff;
      alm_en <= 1'b1;
      rpc_host_i.sleep(1'b0);
      tick(6);
      @(negedge clk) chk("pd", {pd, sq, int_oe}, 3'b100);
      rpc_host_i.cyc(1'b0, 1'b1);
      @(negedge clk) chk("pd bus", {o_sel, n_wr[7:0]}, 9'h101);
      tick(1);
      alm <= 1'b1;
      tick(1);
      alm <= 1'b0;
      tick(2);
      @(negedge clk) chk("wake", {int_o, int_oe, st[7]}, 3'b011);
      rpc_host_i.sleep(1'b1);
      tick(6);
      @(negedge clk) chk("resume", {pd, int_oe, sq}, 3'b011);
      tick(1);
      rst_n <= 1'b0;
      tick(5);
      @(negedge clk) chk("rst pin", {int_o, st}, 9'h100);
      tick(1);
      rst_n <= 1'b1;
   endtask
   // Power-down asked in mid-write: the write lands in the same cycle the mode enters.
   task t_pend();
      fork
         rpc_host_i.cyc(1'b1, 1'b1);
         begin
            tick(9);
            rpc_host_i.pd_req(1'b0);
         end
      join
      @(negedge clk) chk("pend", {pd, n_wr[7:0]}, 9'h102);
   endtask
   initial begin
      {srst, rst_n, cwr, alm, alm_en, rate, taps} = {4'b1100, 21'h0};
      {n_fail, comparisons, n_wr, n_rd, cyc_cnt} = '0;
      tick(10);
      srst <= 1'b0;
      tick(4);
      t_sel();
      t_rates();
      t_sleep();
      t_pend();
      finish_test();
   end
endmodule // testbench
bind rpc_pin_ctrl rpc_chk rpc_chk_i (.*);
